/* File: include/slh_pkg.sv */
// slh_pkg: constants, states and carriers of the segment lcd host input block
// assumes one 25 MHz system clock; the 100 kHz oscillator is a derived tick
package slh_pkg;
  // clock and oscillator timing
  localparam int unsigned CLK_FREQ_HZ     = 25_000_000;
  localparam int unsigned OSC_FREQ_HZ     = 100_000;
  localparam int unsigned OSC_DIV         = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam logic [7:0]  OSC_DIV_LAST    = 8'(OSC_DIV - 1);
  // processing time in oscillator clocks: digit write long, others short
  localparam logic [3:0]  BUSY_DIGIT_OSC  = 4'hA;
  localparam logic [3:0]  BUSY_SHORT_OSC  = 4'h3;
  // write counter last positions
  localparam logic [1:0]  LAST_WIDE       = 2'h1;
  localparam logic [1:0]  LAST_NARROW     = 2'h3;
  // command type field, top two bits of the first byte or nibble
  localparam logic [1:0]  CMD_DIGIT       = 2'h0;
  localparam logic [1:0]  CMD_BIT         = 2'h1;
  localparam logic [1:0]  CMD_MODE        = 2'h2;
  localparam logic [1:0]  CMD_ONE_BYTE    = 2'h3;
  // mode byte field positions (wide second byte / narrow third and fourth nibbles)
  localparam int unsigned MODE_OFF_POS    = 0;
  localparam int unsigned MODE_RDY_POS    = 1;
  localparam int unsigned MODE_EXT_POS    = 2;
  localparam int unsigned MODE_DRV_LSB    = 3;
  localparam int unsigned MODE_DSP_LSB    = 5;
  localparam int unsigned BIT_VAL_POS     = 7;
  // reset and sync values of the mode flags
  localparam logic        OFF_RESET       = 1'b1;
  localparam logic        RDY_RESET       = 1'b0;
  localparam logic        EXT_RESET       = 1'b1;
  localparam logic [1:0]  DRV_RESET       = 2'h0;
  localparam logic [1:0]  DSP_RESET       = 2'h0;

  typedef enum logic [2:0] {
    SLH_IDLE = 3'b001,
    SLH_BUSY = 3'b010,
    SLH_HOLD = 3'b100
  } slh_state_e;

  // host write pins
  typedef struct packed {
    logic       cs_n;
    logic       we_n;
    logic       ready_gate_n;
    logic [7:0] data;
  } slh_host_s;

  // latched modes
  typedef struct packed {
    logic       off;
    logic       ready_mode;
    logic       ext_supply;
    logic [1:0] drive_mode;
    logic [1:0] disp_mode;
  } slh_mode_s;

  // display ram write request
  typedef struct packed {
    logic       digit_we;
    logic       bit_we;
    logic [5:0] segment_index;
    logic [1:0] common_index;
    logic [7:0] data;
  } slh_ram_s;
endpackage : slh_pkg

/* File: design/slh_ctrl.sv */
// slh_ctrl: host write assembly, command decode, busy/ready, standby and sync
// assumes host pins are asynchronous to clk_in; display ram lives outside
`timescale 1ns/10ps
module slh_ctrl
  import slh_pkg::*;
(
  // clock and reset
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  // host pins
  input  wire slh_host_s host_in,
  input  wire logic      narrow_in,
  input  wire logic      sync_in,
  input  wire logic      standby_request_in,
  // ready pin, open drain: driven low while oe is high
  output logic           ready_out,
  output logic           ready_oe_out,
  // display ram write port
  output slh_ram_s       ram_out,
  // modes and lcd control
  output slh_mode_s      mode_out,
  output logic           lcd_blank_out,
  output logic           timing_reset_out,
  output logic           osc_stop_out
);

  slh_host_s  host_s1_reg;
  slh_host_s  host_s2_reg;
  logic [2:0] ctl_s1_reg;
  logic [2:0] ctl_s2_reg;
  logic       we_n_d_reg;
  logic       rst_d_reg;
  logic       narrow_reg;
  logic       sync_s;
  logic       stby_s;
  logic       nar_s;
  logic [1:0] cnt_reg;
  logic [7:0] first_reg;
  logic [3:0] nib2_reg;
  logic [3:0] nib3_reg;
  logic [7:0] div_reg;
  logic       tick;
  logic [3:0] busy_reg;
  slh_state_e state_reg;
  slh_mode_s  mode_reg;
  slh_ram_s   ram_reg;
  logic       ready_low_reg;
  logic       wr_edge;
  logic       wr_take;
  logic       sel_reset;
  logic       is_first;
  logic       one_byte;
  logic [1:0] cnt_last;
  logic       cmd_done;
  logic [1:0] cmd_type;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_data;
  logic       busy_now;
  logic       ready_pull;

  // two-stage synchronisers for every pin; stage one feeds stage two only
  always_ff @(posedge clk_in) begin
    host_s1_reg <= host_in;
    host_s2_reg <= host_s1_reg;
    ctl_s1_reg  <= {narrow_in, standby_request_in, sync_in};
    ctl_s2_reg  <= ctl_s1_reg;
  end
  assign sync_s = ctl_s2_reg[0];
  assign stby_s = ctl_s2_reg[1];
  assign nar_s  = ctl_s2_reg[2];

  // variant strap caught during reset and one edge after, so a short
  // reset still sees the strap through both synchroniser stages
  always_ff @(posedge clk_in) begin
    rst_d_reg <= rst_in;
    if (rst_in | rst_d_reg) begin
      narrow_reg <= nar_s;
    end
  end

  // strobe edge detect on the synchronised copy
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      we_n_d_reg <= 1'b1;
    end else begin
      we_n_d_reg <= host_s2_reg.we_n;
    end
  end

  // data is taken at the rising strobe edge like a static ram write
  assign wr_edge   = host_s2_reg.we_n & ~we_n_d_reg & ~host_s2_reg.cs_n;
  assign busy_now  = (state_reg != SLH_IDLE);
  assign wr_take   = wr_edge & ~busy_now & ~stby_s;
  assign sel_reset = ~host_s2_reg.cs_n & ~host_s2_reg.ready_gate_n;
  assign is_first  = (cnt_reg == 2'h0);
  assign cnt_last  = narrow_reg ? LAST_NARROW : LAST_WIDE;
  // a one-byte code only counts in first position, so in the wide variant a pair
  // of them always lands one in first position and realigns the counter
  assign one_byte  = is_first & (narrow_reg ? (host_s2_reg.data[3:2] == CMD_ONE_BYTE)
                                            : (host_s2_reg.data[7:6] == CMD_ONE_BYTE));
  assign cmd_done  = wr_take & ~one_byte & (cnt_reg == cnt_last);

  // write counter: position from the count of accepted writes, cleared by select with gate low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= 2'h0;
    end else if (sel_reset) begin
      cnt_reg <= 2'h0;
    end else if (wr_take) begin
      if (one_byte) begin
        cnt_reg <= 2'h0;
      end else if (cnt_reg == cnt_last) begin
        cnt_reg <= 2'h0;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end

  // collect the earlier pieces of the command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      first_reg <= 8'h00;
      nib2_reg  <= 4'h0;
      nib3_reg  <= 4'h0;
    end else if (wr_take & ~one_byte & ~sel_reset) begin
      if (is_first) begin
        first_reg <= host_s2_reg.data;
      end
      if (cnt_reg == 2'h1) begin
        nib2_reg <= host_s2_reg.data[3:0];
      end
      if (cnt_reg == 2'h2) begin
        nib3_reg <= host_s2_reg.data[3:0];
      end
    end
  end

  // field decode of the completed command
  always_comb begin
    if (narrow_reg) begin
      cmd_type = first_reg[3:2];
      cmd_addr = {first_reg[1:0], nib2_reg};
      cmd_data = {nib3_reg, host_s2_reg.data[3:0]};
    end else begin
      cmd_type = first_reg[7:6];
      cmd_addr = first_reg[5:0];
      cmd_data = host_s2_reg.data;
    end
  end

  // ram write request, one cycle per completed data command
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ram_reg <= '0;
    end else begin
      ram_reg.digit_we <= 1'b0;
      ram_reg.bit_we   <= 1'b0;
      if (cmd_done & ~sel_reset) begin
        ram_reg.segment_index <= cmd_addr;
        ram_reg.data          <= cmd_data;
        ram_reg.common_index  <= narrow_reg ? 2'h0 : cmd_data[1:0];
        ram_reg.digit_we      <= (cmd_type == CMD_DIGIT);
        ram_reg.bit_we        <= (cmd_type == CMD_BIT);
      end
    end
  end

  // mode latch; sync wins so several chips restart from the same state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg <= '{OFF_RESET, RDY_RESET, EXT_RESET, DRV_RESET, DSP_RESET};
    end else if (sync_s) begin
      mode_reg.off        <= OFF_RESET;
      mode_reg.ready_mode <= RDY_RESET;
      mode_reg.ext_supply <= EXT_RESET;
    end else if (cmd_done & ~sel_reset & (cmd_type == CMD_MODE)) begin
      mode_reg.off        <= cmd_data[MODE_OFF_POS];
      mode_reg.ready_mode <= cmd_data[MODE_RDY_POS];
      if (!narrow_reg) begin
        mode_reg.ext_supply <= cmd_data[MODE_EXT_POS];
        mode_reg.drive_mode <= cmd_data[MODE_DRV_LSB +: 2];
        mode_reg.disp_mode  <= cmd_data[MODE_DSP_LSB +: 2];
      end
    end
  end

  // oscillator tick divider; halted in standby like the real oscillator
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_reg <= 8'h00;
    end else if (stby_s) begin
      div_reg <= div_reg;
    end else if (div_reg == OSC_DIV_LAST) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign tick = ~stby_s & (div_reg == OSC_DIV_LAST);

  // processing state machine, counted in oscillator clocks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= SLH_IDLE;
      busy_reg  <= 4'h0;
    end else begin
      case (state_reg)
        SLH_IDLE: begin
          if (cmd_done & ~sel_reset) begin
            state_reg <= SLH_BUSY;
            busy_reg  <= (cmd_type == CMD_DIGIT) ? BUSY_DIGIT_OSC : BUSY_SHORT_OSC;
          end
        end
        SLH_BUSY: begin
          if (stby_s) begin
            state_reg <= SLH_HOLD;
          end else if (tick) begin
            if (busy_reg == 4'h1) begin
              state_reg <= SLH_IDLE;
              busy_reg  <= 4'h0;
            end else begin
              busy_reg <= busy_reg - 4'h1;
            end
          end
        end
        SLH_HOLD: begin
          if (!stby_s) begin
            state_reg <= SLH_BUSY;
          end
        end
        default: begin
          state_reg <= SLH_IDLE;
          busy_reg  <= 4'h0;
        end
      endcase
    end
  end

  // ready pull-down; bus mode lets a shared bus see it only when addressed;
  // defined from reset on, so the pin never floats before the first mode set
  assign ready_pull = busy_now & (mode_reg.ready_mode | sel_reset);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ready_low_reg <= 1'b0;
      ready_out     <= 1'b1;
    end else begin
      ready_low_reg <= ready_pull;
      ready_out     <= ~ready_pull;
    end
  end
  assign ready_oe_out = ready_low_reg;

  // lcd control outputs, registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lcd_blank_out    <= 1'b1;
      timing_reset_out <= 1'b1;
      osc_stop_out     <= 1'b0;
    end else begin
      lcd_blank_out    <= mode_reg.off | stby_s;
      timing_reset_out <= sync_s;
      osc_stop_out     <= stby_s;
    end
  end
  assign ram_out  = ram_reg;
  assign mode_out = mode_reg;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_port_ready_low: assert property (
    (busy_now & mode_reg.ready_mode) |=> ready_oe_out)
    else $error("port mode busy did not pull ready low");
  a_bus_ready_gate: assert property (
    (~mode_reg.ready_mode & ~sel_reset) |=> ~ready_oe_out)
    else $error("bus mode pulled ready low while not addressed");
  a_idle_ready_high: assert property (
    ~busy_now |=> ready_out)
    else $error("ready low while idle");
  a_sync_forces_off: assert property (
    sync_s |=> (mode_reg.off & ~mode_reg.ready_mode) ##1 lcd_blank_out)
    else $error("sync did not force off and bus ready mode");
  a_sel_resets_cnt: assert property (
    sel_reset |=> (cnt_reg == 2'h0))
    else $error("select and gate low did not clear counter");
  a_one_byte_drop: assert property (
    (wr_take & one_byte & ~sel_reset) |=> (cnt_reg == 2'h0) && !ram_reg.digit_we
                                          && !ram_reg.bit_we)
    else $error("one-byte code advanced the counter");
  a_busy_refuses: assert property (
    (busy_now & wr_edge & ~sel_reset) |=> $stable(cnt_reg))
    else $error("write accepted while busy");
  a_stby_suspends: assert property (
    (state_reg == SLH_HOLD) |-> $stable(busy_reg))
    else $error("processing advanced in standby");
  a_stby_blank: assert property (
    stby_s |=> osc_stop_out && lcd_blank_out)
    else $error("standby did not blank and stop");
  a_wide_pair: assert property (
    (~narrow_reg & wr_take & ~one_byte & (cnt_reg == 2'h1) & ~sel_reset)
      |=> (state_reg == SLH_BUSY) && (cnt_reg == 2'h0))
    else $error("wide command not closed by second byte");
  a_sync_timing: assert property (
    sync_s |=> timing_reset_out)
    else $error("sync did not reset timing");

  c_digit_write: cover property (ram_reg.digit_we);
  c_bit_write:   cover property (ram_reg.bit_we & narrow_reg);
  c_hold_resume: cover property ((state_reg == SLH_HOLD) ##1 (state_reg == SLH_BUSY));
  c_bus_ready:   cover property (ready_oe_out & ~mode_reg.ready_mode);

endmodule : slh_ctrl

/* File: testbench/slh_host_model.sv */
// slh_host_model: microprocessor side that writes the block like a static ram
// assumes the bench calls its tasks; pins change on the falling clock edge
`timescale 1ns/10ps
module slh_host_model
  import slh_pkg::*;
(
  // clock
  input  wire logic clk_in,
  // host pins towards the block
  output slh_host_s host_out
);
  // idle bus: deselected, strobe and gate high
  initial begin
    host_out = '{cs_n: 1'b1, we_n: 1'b1, ready_gate_n: 1'b1, data: 8'h00};
  end

  // one write: select and strobe low, data held well past the strobe rise
  task automatic put(input logic [7:0] d);
    @(negedge clk_in);
    host_out.cs_n = 1'b0;
    host_out.we_n = 1'b0;
    host_out.data = d;
    repeat (4) @(negedge clk_in);
    host_out.we_n = 1'b1;
    repeat (4) @(negedge clk_in);
    host_out.cs_n = 1'b1;
    // released bus shows the inverse, not a stale copy
    host_out.data = ~d;
    repeat (4) @(negedge clk_in);
  endtask : put

  // select and gate low together: counter restart, ready visible in bus mode
  task automatic gate_low;
    @(negedge clk_in);
    host_out.cs_n = 1'b0;
    host_out.ready_gate_n = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask : gate_low

  task automatic gate_high;
    host_out.cs_n = 1'b1;
    host_out.ready_gate_n = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask : gate_high
endmodule : slh_host_model

/* File: testbench/slh_ctrl_tb.sv */
// slh_ctrl_tb: directed test of write assembly, ready, standby and sync
// assumes a 25 MHz clock and the host model as the only writer
`timescale 1ns/10ps
module slh_ctrl_tb;
  import slh_pkg::*;
  logic      clk_in, rst_in, narrow_in, sync_in, standby_request_in;
  logic      ready_out, ready_oe_out, lcd_blank_out, timing_reset_out, osc_stop_out;
  slh_host_s host_in;
  slh_ram_s  ram_out, ram_seen;
  slh_mode_s mode_out;
  int        n_fail, check_count, n_pulse, i;

  slh_host_model host (.clk_in(clk_in), .host_out(host_in));
  slh_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .host_in(host_in), .narrow_in(narrow_in),
    .sync_in(sync_in), .standby_request_in(standby_request_in), .ready_out(ready_out),
    .ready_oe_out(ready_oe_out), .ram_out(ram_out), .mode_out(mode_out),
    .lcd_blank_out(lcd_blank_out), .timing_reset_out(timing_reset_out),
    .osc_stop_out(osc_stop_out));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // catch every ram write pulse; it stands one cycle only
  always @(posedge clk_in) begin
    if (ram_out.digit_we || ram_out.bit_we) begin
      ram_seen <= ram_out;
      n_pulse <= n_pulse + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // bus mode hides ready, so wait past the longest busy span instead
  task automatic wait_done;
    repeat (8) @(negedge clk_in);
    if (mode_out.ready_mode !== 1'b1) repeat (2600) @(negedge clk_in);
    else for (i = 0; i < 3000 && ready_out !== 1'b1; i++) @(negedge clk_in);
    chk(ready_out, 1);
  endtask : wait_done

  task automatic cmd2(input logic [7:0] b1, input logic [7:0] b2);
    host.put(b1);
    host.put(b2);
    wait_done;
  endtask : cmd2

  // one lone host write of a byte or nibble
  task automatic wr_one(input logic [7:0] d);
    host.put(d);
  endtask : wr_one

  task automatic do_reset(input logic nar);
    rst_in = 1'b1;
    narrow_in = nar;
    // two rising edges in reset; the strap is taken on the edge after release
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
  endtask : do_reset

  // watchdog: whole run is about 34k cycles
  initial begin
    #2_400_000;
    n_fail++;
    finish_test;
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    sync_in = 1'b0;
    standby_request_in = 1'b0;
    narrow_in = 1'b0;
    rst_in = 1'b1;
    do_reset(1'b0);
    chk(mode_out, {OFF_RESET, RDY_RESET, EXT_RESET, DRV_RESET, DSP_RESET});
    chk(lcd_blank_out, 1);
    $display("test reset values done");
    cmd2(8'h80, 8'h06);
    chk(mode_out, 7'h30);
    chk(lcd_blank_out, 0);
    cmd2(8'h80, 8'h02);
    chk(mode_out, 7'h20);
    cmd2(8'h80, 8'h06);
    chk(mode_out, 7'h30);
    cmd2(8'h80, 8'h7E);
    chk(mode_out, 7'h3F);
    cmd2(8'h80, 8'h06);
    chk(mode_out, 7'h30);
    $display("test mode set done");
    wr_one(8'h05);
    wr_one(8'hA5);
    chk({ready_out, ready_oe_out}, 2'b01);
    wr_one(8'h07);
    wait_done;
    chk({ram_seen.digit_we, ram_seen.segment_index, ram_seen.data}, {1'b1, 6'h05, 8'hA5});
    cmd2(8'h0A, 8'h11);
    chk({ram_seen.segment_index, ram_seen.data}, {6'h0A, 8'h11});
    $display("test digit write and busy refusal done");
    wr_one(8'h09);
    host.gate_low;
    host.gate_high;
    cmd2(8'h0B, 8'h22);
    chk({ram_seen.segment_index, ram_seen.data}, {6'h0B, 8'h22});
    wr_one(8'hC0);
    cmd2(8'h0C, 8'h33);
    chk({ram_seen.segment_index, ram_seen.data}, {6'h0C, 8'h33});
    cmd2(8'h0D, 8'hC0);
    wr_one(8'hC0);
    cmd2(8'h0E, 8'h44);
    chk({ram_seen.segment_index, ram_seen.data}, {6'h0E, 8'h44});
    chk(n_pulse, 6);
    cmd2(8'h4A, 8'h83);
    chk({ram_seen.bit_we, ram_seen.common_index}, {1'b1, 2'h3});
    chk({ram_seen.segment_index, ram_seen.data}, {6'h0A, 8'h83});
    $display("test counter restart done");
    cmd2(8'h80, 8'h04);
    chk(mode_out, 7'h10);
    wr_one(8'h0F);
    wr_one(8'h55);
    chk(ready_out, 1);
    host.gate_low;
    chk({ready_out, ready_oe_out}, 2'b01);
    host.gate_high;
    chk(ready_out, 1);
    wait_done;
    chk({ram_seen.segment_index, ram_seen.data}, {6'h0F, 8'h55});
    $display("test bus mode ready done");
    cmd2(8'h80, 8'h06);
    wr_one(8'h10);
    wr_one(8'h66);
    standby_request_in = 1'b1;
    repeat (3000) @(negedge clk_in);
    chk(ready_out, 0);
    chk({osc_stop_out, lcd_blank_out, mode_out}, {2'b11, 7'h30});
    standby_request_in = 1'b0;
    for (i = 0; i < 2630 && ready_out !== 1'b1; i++) @(negedge clk_in);
    chk({ready_out, osc_stop_out}, 2'b10);
    $display("test standby done");
    sync_in = 1'b1;
    repeat (6) @(negedge clk_in);
    chk({timing_reset_out, lcd_blank_out, mode_out}, {2'b11, 7'h50});
    sync_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk(timing_reset_out, 0);
    cmd2(8'h80, 8'h06);
    chk(mode_out, 7'h30);
    $display("test sync done");
    do_reset(1'b1);
    wr_one(8'h08);
    wr_one(8'h00);
    wr_one(8'h00);
    wr_one(8'h02);
    wait_done;
    chk(mode_out, 7'h30);
    wr_one(8'h0C);
    wr_one(8'h00);
    wr_one(8'h03);
    wr_one(8'h0A);
    wr_one(8'h05);
    wait_done;
    chk({ram_seen.digit_we, ram_seen.segment_index, ram_seen.data}, {1'b1, 6'h03, 8'hA5});
    wr_one(8'h00);
    wr_one(8'h01);
    host.gate_low;
    host.gate_high;
    wr_one(8'h05);
    wr_one(8'h05);
    wr_one(8'h08);
    wr_one(8'h00);
    wait_done;
    chk({ram_seen.bit_we, ram_seen.segment_index, ram_seen.data[7]}, {1'b1, 6'h15, 1'b1});
    chk(ram_seen.common_index, 2'h0);
    $display("test narrow variant done");
    finish_test;
  end
endmodule : slh_ctrl_tb
